//--- src/hts_switch.sv
// Task switch engine with APB registers and a memory master port
`timescale 1ns/1ps
`include "hts_regs.svh"
module hts_switch
    import hts_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [31:0] mem_wdata,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack,
    output logic             fetch_restart,
    output logic      [31:0] fetch_addr,
    output logic      [31:0] page_directory_base,
    output logic             pdb_load,
    output logic      [15:0] local_table_sel,
    output logic      [15:0] task_register_sel
);
    hts_state_t  state_reg;
    hts_kind_t   kind_reg;
    hts_kind_t   cmd_kind;
    logic [31:0] ctx_reg [0:25];
    logic [31:0] buf_reg [0:25];
    logic [15:0] sel_reg;
    logic [15:0] sel_reg_tr;
    logic [31:0] tr_base_reg;
    logic [19:0] tr_lim_reg;
    logic [31:0] tr_attr_reg;
    logic [31:0] ent_reg;
    logic [31:0] dlo_reg;
    logic [31:0] dhi_reg;
    logic [4:0]  cnt_reg;
    logic [1:0]  ctrl_reg;
    logic [31:0] gdt_reg;
    logic [31:0] idt_reg;
    logic        done_reg;
    logic        fault_reg;
    logic        nosw_reg;
    logic [3:0]  code_reg;
    logic [31:0] op_addr;
    logic        op_we;
    logic [31:0] op_wdata;
    logic [31:0] rd_data;
    logic        hit;
    logic [3:0]  fcode;
    logic        acked;
    logic        commit;
    logic        nesting;
    logic        cmd_go;
    logic        nosw_now;
    logic        wr_en;
    logic        ctx_wr;
    logic [31:0] new_base;
    logic [19:0] new_lim;
    logic [3:0]  dtype;
    logic [31:0] word_off;

    assign wr_en    = psel && penable && pwrite;
    assign cmd_go   = wr_en && paddr == `HTS_OFF_CMD && state_reg == S_IDLE;
    assign ctx_wr   = wr_en && paddr[7] && state_reg == S_IDLE;
    assign cmd_kind = hts_kind_t'(pwdata[2:0]);
    assign acked    = mem_req && mem_ack;
    assign commit   = state_reg == S_COMMIT;
    assign nesting  = kind_reg inside {K_CALL, K_INT, K_EXC};
    assign new_base = {dhi_reg[31:24], dhi_reg[7:0], dlo_reg[31:16]};
    assign new_lim  = {dhi_reg[19:16], dlo_reg[15:0]};
    assign dtype    = dhi_reg[11:8];
    assign word_off = {25'h0, cnt_reg, 2'b00};
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !hit;

    assign page_directory_base = ctx_reg[`HTS_W_PDB]; // R3 R14
    assign local_table_sel     = ctx_reg[`HTS_W_LDT][15:0]; // R13
    assign task_register_sel   = sel_reg_tr;

    function automatic logic [31:0] gdt_ent(input logic [15:0] s);
        gdt_ent = gdt_reg + {16'h0, s[15:3], 3'b000};
    endfunction : gdt_ent

    // Fault and no-switch decisions shared by the sequencer and status
    always_comb begin
        fcode = `HTS_F_NONE;
        if (cmd_go && !ctrl_reg[`HTS_CTRL_PM]) begin
            fcode = `HTS_F_NOTPM; // R1
        end else if (cmd_go && pwdata[2:0] > 3'h5) begin
            fcode = `HTS_F_TYPE; // R4
        end
        if (state_reg == S_GATE && acked && cnt_reg == 5'd1
            && mem_rdata[11:8] != `HTS_TYPE_GATE
            && kind_reg inside {K_INT, K_EXC}) begin
            fcode = `HTS_F_NOGATE; // R7
        end
        if (state_reg == S_CHECK) begin
            if (dtype != `HTS_TYPE_IDLE && dtype != `HTS_TYPE_BUSY) begin
                fcode = `HTS_F_TYPE;
            end else if (sel_reg == sel_reg_tr && kind_reg != K_LTR) begin
                fcode = `HTS_F_RECUR; // R11
            end else if (new_lim < `HTS_MIN_LIMIT) begin
                fcode = `HTS_F_LIMIT; // R20
            end else if ((kind_reg == K_INTERRUPT_RETURN_OP)
                         != (dtype == `HTS_TYPE_BUSY)) begin
                fcode = `HTS_F_BUSY; // R18
            end
        end
    end

    assign nosw_now = cmd_go && fcode == `HTS_F_NONE && cmd_kind == K_INTERRUPT_RETURN_OP
                      && !ctx_reg[`HTS_W_FLAGS][`HTS_NT_BIT]; // R5

    // Memory operation of the current step
    always_comb begin
        op_addr  = 32'h0;
        op_we    = 1'b0;
        op_wdata = 32'h0;
        unique case (state_reg)
            S_GATE, S_DESC: op_addr = ent_reg + word_off;
            S_SAVE: begin
                op_addr  = tr_base_reg + word_off; // R19
                op_we    = 1'b1;
                op_wdata = ctx_reg[cnt_reg];
                if (cnt_reg == `HTS_W_FLAGS && kind_reg == K_INTERRUPT_RETURN_OP) begin
                    op_wdata[`HTS_NT_BIT] = 1'b0;
                end
            end
            S_OLDD: begin
                op_addr  = gdt_ent(sel_reg_tr) + 32'h4;
                op_we    = 1'b1;
                op_wdata = {tr_attr_reg[31:12], `HTS_TYPE_IDLE,
                            tr_attr_reg[7:0]}; // R18
            end
            S_LOAD: op_addr = new_base + word_off; // R19
            S_LINK: begin
                op_addr  = new_base;
                op_we    = 1'b1;
                op_wdata = {16'h0, sel_reg_tr}; // R10
            end
            S_NEWD: begin
                op_addr  = ent_reg + 32'h4;
                op_we    = 1'b1;
                op_wdata = {dhi_reg[31:12], `HTS_TYPE_BUSY,
                            dhi_reg[7:0]}; // R18
            end
            S_IDLE, S_CHECK, S_COMMIT: begin
            end
        endcase
    end

    // Sequencer; at least one idle cycle between memory operations
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            kind_reg  <= K_CALL;
            sel_reg   <= 16'h0000;
            ent_reg   <= 32'h0000_0000;
            cnt_reg   <= 5'h00;
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
        end else if (state_reg == S_IDLE) begin
            cnt_reg <= 5'h00;
            if (cmd_go && fcode == `HTS_F_NONE && !nosw_now) begin // R1 R4
                kind_reg <= cmd_kind;
                sel_reg  <= pwdata[31:16];
                ent_reg  <= gdt_ent(pwdata[31:16]);
                state_reg <= S_GATE; // R6
                if (cmd_kind inside {K_INT, K_EXC}) begin
                    ent_reg <= idt_reg + {21'h0, pwdata[23:16], 3'b000};
                end else if (cmd_kind == K_INTERRUPT_RETURN_OP) begin
                    sel_reg   <= ctx_reg[`HTS_W_LINK][15:0]; // R12
                    ent_reg   <= gdt_ent(ctx_reg[`HTS_W_LINK][15:0]);
                    state_reg <= S_DESC;
                end else if (cmd_kind == K_LTR) begin
                    state_reg <= S_DESC;
                end
            end
        end else if (state_reg == S_CHECK) begin
            if (fcode != `HTS_F_NONE) begin
                state_reg <= S_IDLE;
            end else if (kind_reg == K_LTR) begin
                state_reg <= S_NEWD;
            end else begin
                cnt_reg   <= `HTS_W_IP;
                state_reg <= S_SAVE; // R8
            end
        end else if (commit) begin
            state_reg <= S_IDLE;
        end else if (!mem_req) begin
            mem_req   <= 1'b1;
            mem_we    <= op_we;
            mem_addr  <= op_addr;
            mem_wdata <= op_wdata;
        end else if (mem_ack) begin
            mem_req <= 1'b0;
            cnt_reg <= cnt_reg + 5'd1;
            unique case (state_reg)
                S_GATE: begin
                    if (cnt_reg == 5'd1) begin
                        state_reg <= S_CHECK;
                        if (mem_rdata[11:8] == `HTS_TYPE_GATE) begin
                            sel_reg   <= dlo_reg[31:16]; // R6
                            ent_reg   <= gdt_ent(dlo_reg[31:16]);
                            cnt_reg   <= 5'h00;
                            state_reg <= S_DESC;
                        end else if (fcode != `HTS_F_NONE) begin
                            state_reg <= S_IDLE;
                        end
                    end
                end
                S_DESC: begin
                    if (cnt_reg == 5'd1) begin
                        state_reg <= S_CHECK;
                    end
                end
                S_SAVE: begin
                    if (cnt_reg == `HTS_W_DYN_LAST) begin
                        cnt_reg   <= 5'h00;
                        state_reg <= (kind_reg inside {K_JMP, K_INTERRUPT_RETURN_OP})
                                     ? S_OLDD : S_LOAD;
                    end
                end
                S_OLDD: begin
                    cnt_reg   <= 5'h00;
                    state_reg <= S_LOAD;
                end
                S_LOAD: begin
                    if (cnt_reg == `HTS_W_LAST) begin
                        state_reg <= nesting ? S_LINK
                                   : (kind_reg == K_INTERRUPT_RETURN_OP ? S_COMMIT : S_NEWD);
                    end
                end
                S_LINK: state_reg <= S_NEWD;
                S_NEWD: state_reg <= S_COMMIT;
                S_IDLE, S_CHECK, S_COMMIT: begin
                end
            endcase
        end
    end

    // Captured descriptor and incoming context; held until commit
    always_ff @(posedge pclk) begin
        if (acked && (state_reg == S_GATE || state_reg == S_DESC)) begin
            if (cnt_reg == 5'd0) begin
                dlo_reg <= mem_rdata;
            end else begin
                dhi_reg <= mem_rdata;
            end
        end
        if (acked && state_reg == S_LOAD) begin
            buf_reg[cnt_reg] <= mem_rdata; // R17 R21
        end
    end

    // Architectural context; changes only at commit or by software
    generate
        for (genvar i = 0; i < 26; i++) begin : g_ctx
            logic [31:0] ld_word;
            if (i == 0) begin : g_link
                assign ld_word = nesting ? {16'h0, sel_reg_tr}
                                         : buf_reg[i]; // R10
            end else if (i == 9) begin : g_flags
                assign ld_word = buf_reg[i]
                    | {17'h0, nesting, 14'h0}; // R12
            end else begin : g_plain
                assign ld_word = buf_reg[i];
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctx_reg[i] <= (i == 9) ? `HTS_FLAGS_RST : 32'h0;
                end else if (commit && kind_reg != K_LTR) begin
                    ctx_reg[i] <= ld_word; // R8 R16 R21
                end else if (ctx_wr && paddr[6:2] == 5'(i)) begin
                    ctx_reg[i] <= pwdata;
                end
            end
        end
    endgenerate

    // Task register and fetch redirect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg_tr    <= 16'h0000;
            tr_base_reg   <= 32'h0000_0000;
            tr_lim_reg    <= 20'h0_0000;
            tr_attr_reg   <= 32'h0000_0000;
            fetch_restart <= 1'b0;
            fetch_addr    <= 32'h0000_0000;
            pdb_load      <= 1'b0;
        end else begin
            fetch_restart <= commit && kind_reg != K_LTR;
            pdb_load      <= commit && kind_reg != K_LTR
                             && ctrl_reg[`HTS_CTRL_PG]; // R3
            if (commit) begin
                sel_reg_tr  <= sel_reg; // R2
                tr_base_reg <= new_base;
                tr_lim_reg  <= new_lim;
                tr_attr_reg <= {dhi_reg[31:12], `HTS_TYPE_BUSY,
                                dhi_reg[7:0]};
                fetch_addr  <= buf_reg[`HTS_W_IP]; // R9
            end
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `HTS_CTRL_RST;
            gdt_reg  <= 32'h0000_0000;
            idt_reg  <= 32'h0000_0000;
        end else if (wr_en && paddr == `HTS_OFF_CTRL) begin
            ctrl_reg <= pwdata[1:0];
        end else if (wr_en && paddr == `HTS_OFF_GDT) begin
            gdt_reg <= pwdata;
        end else if (wr_en && paddr == `HTS_OFF_IDT) begin
            idt_reg <= pwdata;
        end
    end

    // Sticky status; a new event wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_reg  <= 1'b0;
            fault_reg <= 1'b0;
            nosw_reg  <= 1'b0;
            code_reg  <= `HTS_F_NONE;
        end else begin
            if (wr_en && paddr == `HTS_OFF_STAT) begin
                done_reg  <= done_reg && !pwdata[`HTS_ST_DONE];
                fault_reg <= fault_reg && !pwdata[`HTS_ST_FAULT];
                nosw_reg  <= nosw_reg && !pwdata[`HTS_ST_NOSW];
            end
            if (commit) begin
                done_reg <= 1'b1;
            end
            if (nosw_now) begin
                nosw_reg <= 1'b1;
            end
            if (fcode != `HTS_F_NONE) begin
                fault_reg <= 1'b1;
                code_reg  <= fcode;
            end
        end
    end

    // Read mux; data is registered in the setup cycle, zero wait states
    always_comb begin
        hit     = 1'b1;
        rd_data = 32'h0000_0000;
        if (paddr[7]) begin
            hit     = paddr[6:2] <= `HTS_W_LAST && paddr[1:0] == 2'b00;
            rd_data = hit ? ctx_reg[paddr[6:2]] : 32'h0000_0000;
        end else begin
            unique case (paddr)
                `HTS_OFF_CTRL:   rd_data = {30'h0, ctrl_reg};
                `HTS_OFF_GDT:    rd_data = gdt_reg;
                `HTS_OFF_IDT:    rd_data = idt_reg;
                `HTS_OFF_CMD:    rd_data = 32'h0000_0000;
                `HTS_OFF_STAT:   rd_data = {24'h0, code_reg, nosw_reg,
                    fault_reg, done_reg, state_reg != S_IDLE};
                `HTS_OFF_TRSEL:  rd_data = {16'h0, sel_reg_tr};
                `HTS_OFF_TRBASE: rd_data = tr_base_reg;
                `HTS_OFF_TRLIM:  rd_data = {12'h0, tr_lim_reg};
                default:         hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= rd_data;
        end
    end

    sequence s_enter_load;
        state_reg != S_LOAD ##1 state_reg == S_LOAD;
    endsequence
    sequence s_quiet_ctx;
        $stable(ctx_reg[`HTS_W_IP]) && $stable(ctx_reg[`HTS_W_PDB]);
    endsequence

    property p_pm_only;
        @(posedge pclk) disable iff (!presetn)
        cmd_go && !ctrl_reg[`HTS_CTRL_PM]
            |=> state_reg == S_IDLE && fault_reg;
    endproperty
    a_pm_only: assert property (p_pm_only) // R1
        else $error("switch started outside protected mode");
    property p_interrupt_return_op_nt;
        @(posedge pclk) disable iff (!presetn)
        nosw_now |=> state_reg == S_IDLE ##1 !fetch_restart;
    endproperty
    a_interrupt_return_op_nt: assert property (p_interrupt_return_op_nt) // R5
        else $error("return without nested flag switched task");
    property p_save_first;
        @(posedge pclk) disable iff (!presetn)
        s_enter_load |-> $past(state_reg, 2) inside {S_SAVE, S_OLDD};
    endproperty
    a_save_first: assert property (p_save_first) // R8
        else $error("load began before save finished");
    property p_no_early;
        @(posedge pclk) disable iff (!presetn)
        state_reg inside {S_SAVE, S_LOAD, S_LINK, S_NEWD} |=> s_quiet_ctx;
    endproperty
    a_no_early: assert property (p_no_early) // R21
        else $error("context changed before commit");
    property p_resume;
        @(posedge pclk) disable iff (!presetn)
        fetch_restart |-> fetch_addr == ctx_reg[`HTS_W_IP]
            && task_register_sel == sel_reg;
    endproperty
    a_resume: assert property (p_resume) // R9
        else $error("fetch address not the loaded pointer");
    property p_recur;
        @(posedge pclk) disable iff (!presetn)
        state_reg == S_CHECK && sel_reg == sel_reg_tr && kind_reg != K_LTR
            && dtype inside {`HTS_TYPE_IDLE, `HTS_TYPE_BUSY}
            |=> state_reg == S_IDLE && code_reg == `HTS_F_RECUR;
    endproperty
    a_recur: assert property (p_recur) // R11
        else $error("switch to own task not refused");
    property p_limit;
        @(posedge pclk) disable iff (!presetn)
        state_reg == S_CHECK && new_lim < `HTS_MIN_LIMIT
            |=> fault_reg ##1 state_reg == S_IDLE;
    endproperty
    a_limit: assert property (p_limit) // R20
        else $error("short segment limit not faulted");
    property p_busy_mark;
        @(posedge pclk) disable iff (!presetn)
        state_reg == S_NEWD && mem_req && mem_we
            |-> mem_wdata[11:8] == `HTS_TYPE_BUSY;
    endproperty
    a_busy_mark: assert property (p_busy_mark) // R18
        else $error("incoming descriptor not marked busy");
    property p_link;
        @(posedge pclk) disable iff (!presetn)
        state_reg == S_LINK && mem_req
            |-> mem_we && mem_addr == new_base
                && mem_wdata[15:0] == sel_reg_tr;
    endproperty
    a_link: assert property (p_link) // R10
        else $error("back link not written correctly");
    property p_window;
        @(posedge pclk) disable iff (!presetn)
        state_reg == S_LOAD && mem_req |-> mem_addr - new_base < 32'd104;
    endproperty
    a_window: assert property (p_window) // R19
        else $error("segment access outside first 104 bytes");
endmodule : hts_switch

//--- src/hts_regs.svh
// Register map and constants of the hardware task switch unit
// What this block does
// R1 - Task dispatch and switching happen only in protected mode.
// R2 - Task register takes selector, base, limit and attributes of loaded task.
// R3 - With paging on, load incoming page directory base into control register.
// R4 - Switch starts only on call, jump, interrupt, exception or return.
// R5 - Interrupt return switches back only when nested task flag is set.
// R6 - Call or jump selector names a state segment or a task gate.
// R7 - Software puts task gates in vector table entries for task handlers.
// R8 - Save running context first, suspend it, then load dispatched context.
// R9 - Resume fetching at the freshly loaded instruction pointer.
// R10 - On a call, store caller selector as back link in called segment.
// R11 - A task may not call or jump to itself.
// R12 - Returning from handler task switches back to the interrupted task.
// R13 - Switch loads incoming local descriptor table selector.
// R14 - Page directory base is reloaded on every switch.
// R15 - Software creates one state segment and loads task register first.
// R16 - Stored state holds everything but task register; table selector only.
// R17 - State covers selectors, registers, flags, pointer, base, stacks, link.
// R18 - Busy type 1011B, inactive 1001B; busy marking guards calls.
// R19 - Access first 104 bytes of each segment at contiguous addresses.
// R20 - Descriptor limit below 67H raises invalid state segment fault.
// R21 - Outgoing context is fully written before any register changes.
`ifndef HTS_REGS_SVH
`define HTS_REGS_SVH
`define HTS_OFF_CTRL    8'h00
`define HTS_OFF_GDT     8'h04
`define HTS_OFF_IDT     8'h08
`define HTS_OFF_CMD     8'h0C
`define HTS_OFF_STAT    8'h10
`define HTS_OFF_TRSEL   8'h14
`define HTS_OFF_TRBASE  8'h18
`define HTS_OFF_TRLIM   8'h1C
`define HTS_OFF_CTX     8'h80
`define HTS_CTRL_PM     0
`define HTS_CTRL_PG     1
`define HTS_CTRL_RST    2'h0
`define HTS_CMD_SEL_LSB 16
`define HTS_ST_BUSY     0
`define HTS_ST_DONE     1
`define HTS_ST_FAULT    2
`define HTS_ST_NOSW     3
`define HTS_ST_CODE_LSB 4
`define HTS_W_LINK      5'd0
`define HTS_W_PDB       5'd7
`define HTS_W_IP        5'd8
`define HTS_W_FLAGS     5'd9
`define HTS_W_DYN_LAST  5'd23
`define HTS_W_LDT       5'd24
`define HTS_W_LAST      5'd25
`define HTS_NT_BIT      14
`define HTS_FLAGS_RST   32'h0000_0002
`define HTS_TYPE_IDLE   4'h9
`define HTS_TYPE_BUSY   4'hB
`define HTS_TYPE_GATE   4'h5
`define HTS_MIN_LIMIT   20'h0_0067
`define HTS_F_NONE      4'h0
`define HTS_F_NOTPM     4'h1
`define HTS_F_TYPE      4'h2
`define HTS_F_RECUR     4'h3
`define HTS_F_LIMIT     4'h4
`define HTS_F_BUSY      4'h5
`define HTS_F_NOGATE    4'h6
`endif

//--- src/hts_pkg.sv
// Types of the hardware task switch unit
package hts_pkg;
    typedef enum logic [2:0] {
        K_CALL, K_JMP, K_INT, K_EXC, K_INTERRUPT_RETURN_OP, K_LTR
    } hts_kind_t;
    typedef enum logic [3:0] {
        S_IDLE, S_GATE, S_DESC, S_CHECK, S_SAVE, S_OLDD,
        S_LOAD, S_LINK, S_NEWD, S_COMMIT
    } hts_state_t;
endpackage : hts_pkg

//--- tb/hts_mem_model.sv
// Word memory on the far side of the switch unit
`timescale 1ns/1ps
module hts_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic [1:0]  wait_cycles,
    output logic      [31:0] mem_rdata,
    output logic             mem_ack
);
    logic [31:0] mem [0:4095];
    logic [1:0]  cnt_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack   <= 1'b0;
            cnt_reg   <= 2'h0;
            mem_rdata <= 32'h0;
        end else begin
            mem_ack   <= 1'b0;
            // Toggles between answers so stale data never looks valid
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                cnt_reg <= cnt_reg + 2'h1;
                if (cnt_reg == wait_cycles) begin
                    mem_ack <= 1'b1;
                    cnt_reg <= 2'h0;
                    if (mem_we)
                        mem[mem_addr[13:2]] <= mem_wdata;
                    else
                        mem_rdata <= mem[mem_addr[13:2]];
                end
            end
        end
    end
endmodule : hts_mem_model

//--- tb/hts_switch_tb.sv
// Directed bench for the task switch unit
`timescale 1ns/1ps
module hts_switch_tb;
    import hts_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, re, mem_req, mem_we, mem_ack;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] fetch_addr, page_directory_base, rq, st, fa, w;
    logic fetch_restart, pdb_load;
    logic [15:0] local_table_sel, task_register_sel;
    logic [1:0] wait_cycles = 2'h0;
    int mismatches = 0, n_compared = 0, n_pdb = 0;
    always #25 pclk = ~pclk;
    hts_switch u_hts_switch (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we,
        .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .fetch_restart,
        .fetch_addr, .page_directory_base, .pdb_load, .local_table_sel,
        .task_register_sel);
    hts_mem_model u_hts_mem_model (.pclk, .presetn, .mem_req, .mem_we,
        .mem_addr, .mem_wdata, .wait_cycles, .mem_rdata, .mem_ack);
    always @(posedge pclk) if (fetch_restart === 1'b1) begin
        fa <= fetch_addr;
        if (pdb_load === 1'b1) n_pdb <= n_pdb + 1;
    end
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin mismatches++; results(); end
    endtask : apb
    task automatic cmd(input logic [2:0] kind, input logic [15:0] sel);
        int k;
        apb(1'b1, 8'h0C, {sel, 13'h0, kind});
        k = 0;
        do begin
            apb(1'b0, 8'h10, 32'h0);
            k++;
        end while (rq[0] !== 1'b0 && k < 400);
        st = rq;
        apb(1'b1, 8'h10, 32'h0000_000E);
        if (k >= 400) begin mismatches++; results(); end
    endtask : cmd
    task automatic desc(input int a, input logic [31:0] b,
                        input logic [19:0] lim, input logic [3:0] ty);
        u_hts_mem_model.mem[a/4] = {b[15:0], lim[15:0]};
        u_hts_mem_model.mem[a/4+1] = {b[31:24], 4'h0, lim[19:16], 4'h8,
                                      ty, b[23:16]};
    endtask : desc
    function automatic logic [31:0] mw(input int a);
        return u_hts_mem_model.mem[a/4];
    endfunction : mw
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'hA4, 32'h0);
        chk(rq, 32'h0000_0002);
        apb(1'b0, 8'h20, 32'h0);
        chk(re, 1'b1);
        desc(32'h108, 32'h1000, 20'h00067, 4'h9);
        desc(32'h110, 32'h2000, 20'h00067, 4'h9);
        desc(32'h118, 32'h3000, 20'h00066, 4'h9);
        desc(32'h318, 32'h0000_0010, 20'h0, 4'h5);
        // Both segments fully defined so a return loads no unknowns
        for (int i = 0; i < 26; i++) begin
            u_hts_mem_model.mem[32'h800+i] = (i == 9) ? 32'h2 : 32'h200+i;
            u_hts_mem_model.mem[32'h400+i] = 32'h300+i;
        end
        cmd(K_CALL, 16'h0010);
        chk(st[7:2], {4'h1, 2'b01});
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h04, 32'h100);
        apb(1'b1, 8'h08, 32'h300);
        cmd(K_LTR, 16'h0008);
        apb(1'b0, 8'h18, 32'h0);
        chk(rq, 32'h1000);
        w = mw(32'h10C);
        chk(w[11:8], 4'hB);
        for (int i = 8; i < 24; i++) apb(1'b1, 8'(128+4*i), 32'h100+i);
        cmd(K_CALL, 16'h0010);
        chk(st[3:1], 3'b001);
        for (int i = 8; i < 24; i++) begin
            chk(mw(32'h1000+4*i), 32'h100+i);
            apb(1'b0, 8'(128+4*i), 32'h0);
            chk(rq, (i == 9) ? 32'h4002 : 32'h200+i);
        end
        chk(mw(32'h2000), 32'h8);
        chk(fa, 32'h208);
        chk(page_directory_base, 32'h207);
        chk(local_table_sel, 16'h0218);
        chk(task_register_sel, 16'h0010);
        cmd(K_CALL, 16'h0010);
        chk(st[7:2], {4'h3, 2'b01});
        cmd(K_INTERRUPT_RETURN_OP, 16'h0);
        chk(task_register_sel, 16'h0008);
        chk(fa, 32'h108);
        w = mw(32'h114);
        chk(w[11:8], 4'h9);
        cmd(K_INTERRUPT_RETURN_OP, 16'h0);
        chk(st[3:2], 2'b10);
        cmd(K_CALL, 16'h0018);
        chk(st[7:2], {4'h4, 2'b01});
        // Slow memory for the gated interrupt round trip
        wait_cycles <= 2'h2;
        cmd(K_INT, 16'h0003);
        chk(task_register_sel, 16'h0010);
        chk(n_pdb, 3);
        cmd(K_INTERRUPT_RETURN_OP, 16'h0);
        chk(task_register_sel, 16'h0008);
        cmd(K_JMP, 16'h0010);
        chk(task_register_sel, 16'h0010);
        w = mw(32'h10C);
        chk(w[11:8], 4'h9);
        results();
    end
endmodule : hts_switch_tb
